/* File: hdl/eie_params.svh */
`ifndef EIE_PARAMS_SVH
`define EIE_PARAMS_SVH

// Register offsets on the plain register port
`define EIE_ADDR_W 3
`define EIE_OFS_EDGE_PRI 3'h0
`define EIE_OFS_EDGE_WAKE 3'h1
`define EIE_OFS_ENABLE 3'h2
`define EIE_OFS_REQ_FLAG 3'h3
`define EIE_OFS_WAKE_FLAG 3'h4
`define EIE_OFS_EVT_STAT 3'h5
`define EIE_OFS_EVT_MASK 3'h6

// Field positions
`define EIE_BIT_NMI_EDGE 7
`define EIE_BIT_DT_EN 7
`define EIE_BIT_TA_EN 6
`define EIE_BIT_WAKE_EN 5
`define EIE_BIT_DT_FLAG 7
`define EIE_BIT_TA_FLAG 6
`define EIE_NUM_REQ 4
`define EIE_NUM_WAKE 6
`define EIE_WAKE_CONV 5
`define EIE_NUM_EVT 4

// Event status bit positions
`define EIE_EVT_NMI 0
`define EIE_EVT_CONV 1
`define EIE_EVT_REQ 2
`define EIE_EVT_WAKE 3

// Reserved bits that read as one
`define EIE_RSV_EDGE_PRI 8'h70
`define EIE_RSV_EDGE_WAKE 8'hc0
`define EIE_RSV_ENABLE 8'h10
`define EIE_RSV_REQ_FLAG 8'h30
`define EIE_RSV_WAKE_FLAG 8'hc0

// Reset values of the stored fields, and the read data of unmapped offsets
`define EIE_RST_SEL 1'b0
`define EIE_RST_EN 1'b0
`define EIE_RDATA_UNMAPPED 8'h00

`endif

/* File: hdl/eie_pkg.sv */
package eie_pkg;

    typedef struct packed {
        logic nmi;
        logic dt;
        logic ta;
        logic wake;
        logic [3:0] req_pin;
    } eie_cpu_req_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eie_bus_t;

endpackage : eie_pkg

/* File: hdl/eie_edge_det.sv */
`timescale 1ns/1ps

module eie_edge_det #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] pin,
    input wire logic [W-1:0] sel,
    output logic [W-1:0] evt
);

    logic [W-1:0] prev_r;
    logic armed_r;

    // Previous pin level, compared only once it holds a real sample
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_r <= '0;
            armed_r <= 1'b0;
        end else begin
            prev_r <= pin;
            armed_r <= 1'b1;
        end
    end

    // Sel 1 keeps rising edges, sel 0 keeps falling edges
    always_comb begin
        evt = armed_r ? ((pin ^ prev_r) & ~(pin ^ sel)) : '0;
    end

endmodule : eie_edge_det

/* File: hdl/eie_sticky.sv */
`timescale 1ns/1ps

module eie_sticky #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);

    logic [W-1:0] q_r;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_r <= '0;
        end else begin
            q_r <= (q_r & ~clr) | set;
        end
    end

    assign q = q_r;

endmodule : eie_sticky

/* File: hdl/eie_top.sv */
// Notes on behaviour
// - Bit 7 of the primary edge select picks the non-maskable pin edge, 0 falling, 1 rising.
// - Bits 3..0 of the primary edge select pick each request pin edge, 0 falling, 1 rising.
// - Primary bits 6..4 and wakeup bits 7..6 are reserved, read as 1 and ignore writes.
// - Bits 5..0 of the wakeup edge select pick each wakeup pin edge, 0 falling, 1 rising.
// - The wakeup pin 5 edge bit also sets the edge of the converter trigger on that pin.
// - Enable bit 7 lets direct-transition requests reach the CPU only while it is 1.
// - Enable bit 6 lets the timer A overflow request through only while it is 1.
// - Enable bit 5 is one enable shared by all six wakeup pins.
// - Enable bits 3..0 each let the matching request pin through when 1 and block it when 0.
// - Enable bit 4 is reserved, reads as 1 and ignores writes.
// - A request that meets a flag clear in the same cycle is kept and taken afterwards.
// - A pin flag sets on the selected edge, the DT and TA flags while their event input is 1; each clears only when software writes 0 to it.
// - All maskable requests on cpu_req are held off while the CPU mask bit is 1; irq_out ignores it.
`timescale 1ns/1ps
`include "eie_params.svh"

module eie_top (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`EIE_ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic cpu_mask,
    input wire logic nmi_pin,
    input wire logic [`EIE_NUM_REQ-1:0] ext_req_pin,
    input wire logic [`EIE_NUM_WAKE-1:0] wake_pin,
    input wire logic dt_event,
    input wire logic timer_a_ovf,
    output eie_pkg::eie_cpu_req_t cpu_req,
    output logic conv_trig,
    output logic irq_out
);

    eie_pkg::eie_bus_t bus;
    logic nonmaskable_edge_sel_r;
    logic [`EIE_NUM_REQ-1:0] req_pin_edge_sel_r;
    logic [`EIE_NUM_WAKE-1:0] wake_edge_sel_r;
    logic direct_transition_en_r;
    logic timer_a_ovf_en_r;
    logic wake_common_en_r;
    logic [`EIE_NUM_REQ-1:0] req_pin_en_r;
    logic [`EIE_NUM_EVT-1:0] evt_mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    eie_pkg::eie_cpu_req_t cpu_req_r;
    eie_pkg::eie_cpu_req_t cpu_req_nxt;
    logic conv_trig_r;
    logic irq_out_r;
    logic nmi_evt;
    logic [`EIE_NUM_REQ-1:0] req_evt;
    logic [`EIE_NUM_WAKE-1:0] wake_evt;
    logic wr_req_flag;
    logic wr_wake_flag;
    logic wr_evt_stat;
    logic [5:0] req_set;
    logic [5:0] req_clr;
    logic [5:0] req_q;
    logic [`EIE_NUM_WAKE-1:0] wake_clr;
    logic [`EIE_NUM_WAKE-1:0] wake_q;
    logic [`EIE_NUM_EVT-1:0] evt_set;
    logic [`EIE_NUM_EVT-1:0] evt_clr;
    logic [`EIE_NUM_EVT-1:0] evt_q;
    logic [`EIE_NUM_REQ-1:0] req_flag;
    logic dt_flag;
    logic ta_flag;

    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    eie_edge_det #(.W(1)) u_nmi_det (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(nmi_pin),
        .sel(nonmaskable_edge_sel_r),
        .evt(nmi_evt)
    );

    eie_edge_det #(.W(`EIE_NUM_REQ)) u_req_det (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(ext_req_pin),
        .sel(req_pin_edge_sel_r),
        .evt(req_evt)
    );

    eie_edge_det #(.W(`EIE_NUM_WAKE)) u_wake_det (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin(wake_pin),
        .sel(wake_edge_sel_r),
        .evt(wake_evt)
    );

    assign wr_req_flag = bus.wr && (bus.addr == `EIE_OFS_REQ_FLAG);
    assign wr_wake_flag = bus.wr && (bus.addr == `EIE_OFS_WAKE_FLAG);
    assign wr_evt_stat = bus.wr && (bus.addr == `EIE_OFS_EVT_STAT);

    // Edge select register writes, reserved bits not stored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            nonmaskable_edge_sel_r <= `EIE_RST_SEL;
            req_pin_edge_sel_r <= '0;
            wake_edge_sel_r <= '0;
        end else begin
            if (bus.wr && bus.addr == `EIE_OFS_EDGE_PRI) begin
                nonmaskable_edge_sel_r <= bus.wdata[`EIE_BIT_NMI_EDGE];
                req_pin_edge_sel_r <= bus.wdata[`EIE_NUM_REQ-1:0];
            end
            if (bus.wr && bus.addr == `EIE_OFS_EDGE_WAKE) begin
                wake_edge_sel_r <= bus.wdata[`EIE_NUM_WAKE-1:0];
            end
        end
    end

    // Enable register writes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            direct_transition_en_r <= `EIE_RST_EN;
            timer_a_ovf_en_r <= `EIE_RST_EN;
            wake_common_en_r <= `EIE_RST_EN;
            req_pin_en_r <= '0;
        end else if (bus.wr && bus.addr == `EIE_OFS_ENABLE) begin
            direct_transition_en_r <= bus.wdata[`EIE_BIT_DT_EN];
            timer_a_ovf_en_r <= bus.wdata[`EIE_BIT_TA_EN];
            wake_common_en_r <= bus.wdata[`EIE_BIT_WAKE_EN];
            req_pin_en_r <= bus.wdata[`EIE_NUM_REQ-1:0];
        end
    end

    // Event mask register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            evt_mask_r <= '0;
        end else if (bus.wr && bus.addr == `EIE_OFS_EVT_MASK) begin
            evt_mask_r <= bus.wdata[`EIE_NUM_EVT-1:0];
        end
    end

    // flags set on pin edge or dt_event/timer_a_ovf high, cleared by writing 0
    assign req_set = {dt_event, timer_a_ovf, req_evt};
    assign req_clr = wr_req_flag ? ~{bus.wdata[`EIE_BIT_DT_FLAG], bus.wdata[`EIE_BIT_TA_FLAG],
                                     bus.wdata[`EIE_NUM_REQ-1:0]} : 6'h00;
    assign wake_clr = wr_wake_flag ? ~bus.wdata[`EIE_NUM_WAKE-1:0] : 6'h00;

    eie_sticky #(.W(6)) u_req_flags (
        .sys_clk(sys_clk),
        .srst(srst),
        .set(req_set),
        .clr(req_clr),
        .q(req_q)
    );

    eie_sticky #(.W(`EIE_NUM_WAKE)) u_wake_flags (
        .sys_clk(sys_clk),
        .srst(srst),
        .set(wake_evt),
        .clr(wake_clr),
        .q(wake_q)
    );

    assign dt_flag = req_q[5];
    assign ta_flag = req_q[4];
    assign req_flag = req_q[`EIE_NUM_REQ-1:0];

    // Event status, write one to clear
    always_comb begin
        evt_set = '0;
        evt_set[`EIE_EVT_NMI] = nmi_evt;
        evt_set[`EIE_EVT_CONV] = wake_evt[`EIE_WAKE_CONV];
        evt_set[`EIE_EVT_REQ] = |req_evt;
        evt_set[`EIE_EVT_WAKE] = |wake_evt;
    end

    assign evt_clr = wr_evt_stat ? bus.wdata[`EIE_NUM_EVT-1:0] : '0;

    eie_sticky #(.W(`EIE_NUM_EVT)) u_evt_stat (
        .sys_clk(sys_clk),
        .srst(srst),
        .set(evt_set),
        .clr(evt_clr),
        .q(evt_q)
    );

    // Requests toward the CPU
    always_comb begin
        cpu_req_nxt.nmi = nmi_evt;
        cpu_req_nxt.dt = dt_flag && direct_transition_en_r && !cpu_mask;
        cpu_req_nxt.ta = ta_flag && timer_a_ovf_en_r && !cpu_mask;
        cpu_req_nxt.wake = (|wake_q) && wake_common_en_r && !cpu_mask;
        cpu_req_nxt.req_pin = req_flag & req_pin_en_r & {`EIE_NUM_REQ{!cpu_mask}};
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_req_r <= '0;
        end else begin
            cpu_req_r <= cpu_req_nxt;
        end
    end

    // converter trigger on wake pin 5 edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_trig_r <= 1'b0;
        end else begin
            conv_trig_r <= wake_evt[`EIE_WAKE_CONV];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_out_r <= 1'b0;
        end else begin
            irq_out_r <= |((evt_q | evt_set) & ~evt_clr & evt_mask_r)
                         || |(evt_set & evt_mask_r);
        end
    end

    // Read mux
    always_comb begin
        rdata_nxt = `EIE_RDATA_UNMAPPED;
        unique case (bus.addr)
            `EIE_OFS_EDGE_PRI: begin
                rdata_nxt = `EIE_RSV_EDGE_PRI;
                rdata_nxt[`EIE_BIT_NMI_EDGE] = nonmaskable_edge_sel_r;
                rdata_nxt[`EIE_NUM_REQ-1:0] = req_pin_edge_sel_r;
            end
            `EIE_OFS_EDGE_WAKE: begin
                rdata_nxt = `EIE_RSV_EDGE_WAKE;
                rdata_nxt[`EIE_NUM_WAKE-1:0] = wake_edge_sel_r;
            end
            `EIE_OFS_ENABLE: begin
                rdata_nxt = `EIE_RSV_ENABLE;
                rdata_nxt[`EIE_BIT_DT_EN] = direct_transition_en_r;
                rdata_nxt[`EIE_BIT_TA_EN] = timer_a_ovf_en_r;
                rdata_nxt[`EIE_BIT_WAKE_EN] = wake_common_en_r;
                rdata_nxt[`EIE_NUM_REQ-1:0] = req_pin_en_r;
            end
            `EIE_OFS_REQ_FLAG: begin
                rdata_nxt = `EIE_RSV_REQ_FLAG;
                rdata_nxt[`EIE_BIT_DT_FLAG] = dt_flag;
                rdata_nxt[`EIE_BIT_TA_FLAG] = ta_flag;
                rdata_nxt[`EIE_NUM_REQ-1:0] = req_flag;
            end
            `EIE_OFS_WAKE_FLAG: begin
                rdata_nxt = `EIE_RSV_WAKE_FLAG;
                rdata_nxt[`EIE_NUM_WAKE-1:0] = wake_q;
            end
            `EIE_OFS_EVT_STAT: begin
                rdata_nxt[`EIE_NUM_EVT-1:0] = evt_q;
            end
            `EIE_OFS_EVT_MASK: begin
                rdata_nxt[`EIE_NUM_EVT-1:0] = evt_mask_r;
            end
            default: begin
                rdata_nxt = `EIE_RDATA_UNMAPPED;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else if (bus.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign bus_rdata = rdata_r;
    assign cpu_req = cpu_req_r;
    assign conv_trig = conv_trig_r;
    assign irq_out = irq_out_r;

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (srst);

    logic armed_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    sequence s_nmi_rise;
        armed_q && nonmaskable_edge_sel_r && !nmi_pin ##1 nmi_pin && nonmaskable_edge_sel_r;
    endsequence

    sequence s_req0_fall;
        armed_q && !req_pin_edge_sel_r[0] && ext_req_pin[0] ##1
            !ext_req_pin[0] && !req_pin_edge_sel_r[0];
    endsequence

    sequence s_wake2_rise;
        armed_q && wake_edge_sel_r[2] && !wake_pin[2] ##1 !$past(srst) && wake_pin[2]
            && wake_edge_sel_r[2];
    endsequence

    sequence s_wake5_fall;
        armed_q && !wake_edge_sel_r[5] && wake_pin[5] ##1 !wake_pin[5] && !wake_edge_sel_r[5];
    endsequence

    a_nmi_rise_req: assert property (s_nmi_rise |=> cpu_req.nmi)
        else $error("nmi rising edge did not raise the request");

    a_req_fall_flag: assert property (s_req0_fall |=> req_flag[0])
        else $error("request pin 0 falling edge did not set its flag");

    a_rsv_edge_ones: assert property ((bus_rd && bus_addr == `EIE_OFS_EDGE_PRI)
        |=> bus_rdata[6:4] == 3'h7)
        else $error("primary edge reserved bits did not read as one");

    a_rsv_wake_ones: assert property ((bus_rd && bus_addr == `EIE_OFS_EDGE_WAKE)
        |=> bus_rdata[7:6] == 2'h3)
        else $error("wakeup edge reserved bits did not read as one");

    a_wake_rise_flag: assert property (s_wake2_rise |=> wake_q[2])
        else $error("wake pin 2 rising edge did not set its flag");

    a_conv_trig_edge: assert property (s_wake5_fall |=> conv_trig && wake_q[5])
        else $error("wake pin 5 edge did not give trigger and flag together");

    a_dt_gate_off: assert property (!direct_transition_en_r |=> !cpu_req.dt)
        else $error("direct transition request passed while disabled");

    a_ta_gate_on: assert property ((ta_flag && timer_a_ovf_en_r && !cpu_mask)
        |=> cpu_req.ta)
        else $error("timer A request missing while enabled");

    a_wake_common_en: assert property ((wake_q[0] && wake_common_en_r && !cpu_mask)
        |=> cpu_req.wake)
        else $error("wake request missing with shared enable set");

    a_req_pin_block: assert property (!req_pin_en_r[3] |=> !cpu_req.req_pin[3])
        else $error("request pin 3 passed while disabled");

    a_en_bit4_one: assert property ((bus_rd && bus_addr == `EIE_OFS_ENABLE)
        |=> bus_rdata[4])
        else $error("enable bit 4 did not read as one");

    a_set_over_clear: assert property ((wr_req_flag && !bus_wdata[`EIE_BIT_DT_FLAG] && dt_event)
        |=> dt_flag ##1 (cpu_req.dt || !direct_transition_en_r || $past(cpu_mask)))
        else $error("request lost against a flag clear");

    a_flag_sticky: assert property ((ta_flag && !wr_req_flag) |=> ta_flag)
        else $error("timer A flag dropped without a clear");

    a_mask_hold: assert property (cpu_mask |=> !(cpu_req.dt || cpu_req.ta || cpu_req.wake
        || |cpu_req.req_pin))
        else $error("maskable request passed with mask set");

    a_nmi_no_gate: assert property ((nmi_evt && cpu_mask && !direct_transition_en_r)
        |=> cpu_req.nmi)
        else $error("nmi request was gated");

endmodule : eie_top

/* File: tb/eie_pin_model.sv */
`timescale 1ns/1ps
`include "eie_params.svh"

module eie_pin_model (
    input wire logic sys_clk,
    output logic nmi_pin,
    output logic [`EIE_NUM_REQ-1:0] ext_req_pin,
    output logic [`EIE_NUM_WAKE-1:0] wake_pin,
    output logic dt_event,
    output logic timer_a_ovf,
    output logic cpu_mask
);
    // Pins idle low, CPU starts with maskable requests held off
    initial begin
        nmi_pin = 1'b0;
        ext_req_pin = '0;
        wake_pin = '0;
        dt_event = 1'b0;
        timer_a_ovf = 1'b0;
        cpu_mask = 1'b1;
    end

    task automatic drive_pins(input logic lvl);
        @(posedge sys_clk);
        nmi_pin <= lvl;
        ext_req_pin <= {`EIE_NUM_REQ{lvl}};
        wake_pin <= {`EIE_NUM_WAKE{lvl}};
        repeat (4) @(posedge sys_clk);
    endtask : drive_pins

    task automatic pulse_events(input logic dt, input logic ta);
        @(posedge sys_clk);
        dt_event <= dt;
        timer_a_ovf <= ta;
        @(posedge sys_clk);
        dt_event <= 1'b0;
        timer_a_ovf <= 1'b0;
    endtask : pulse_events

    task automatic set_mask(input logic m);
        @(posedge sys_clk);
        cpu_mask <= m;
    endtask : set_mask
endmodule : eie_pin_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "eie_params.svh"

module tb;
    logic sys_clk = 1'b0;
    logic srst;
    logic [`EIE_ADDR_W-1:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    logic cpu_mask;
    logic nmi_pin;
    logic [`EIE_NUM_REQ-1:0] ext_req_pin;
    logic [`EIE_NUM_WAKE-1:0] wake_pin;
    logic dt_event;
    logic timer_a_ovf;
    eie_pkg::eie_cpu_req_t cpu_req;
    logic conv_trig;
    logic irq_out;
    int miscompares = 0;
    int checks = 0;
    int nmi_cnt = 0;
    int conv_cnt = 0;
    int n0;
    int c0;
    logic lv;
    logic [7:0] e;
    logic [7:0] pat [4] = '{8'h00, 8'ha5, 8'h5a, 8'hff};
    logic [7:0] en_tab [9] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h01, 8'h02, 8'h04, 8'h08, 8'hef};

    always #10 sys_clk = ~sys_clk;

    eie_top dut (
        .sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_mask(cpu_mask),
        .nmi_pin(nmi_pin), .ext_req_pin(ext_req_pin), .wake_pin(wake_pin),
        .dt_event(dt_event), .timer_a_ovf(timer_a_ovf), .cpu_req(cpu_req),
        .conv_trig(conv_trig), .irq_out(irq_out)
    );

    eie_pin_model pins (
        .sys_clk(sys_clk), .nmi_pin(nmi_pin), .ext_req_pin(ext_req_pin),
        .wake_pin(wake_pin), .dt_event(dt_event), .timer_a_ovf(timer_a_ovf),
        .cpu_mask(cpu_mask)
    );

    // Counts one-cycle pulses of the nmi request and converter trigger
    always @(posedge sys_clk) begin
        if (cpu_req.nmi === 1'b1) begin
            nmi_cnt++;
        end
        if (conv_trig === 1'b1) begin
            conv_cnt++;
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        chk(name, exp, bus_rdata);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end

    initial begin
        srst <= 1'b1;
        bus_addr <= '0;
        bus_wdata <= 8'h00;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        rd_chk("edge_pri", `EIE_OFS_EDGE_PRI, 8'h70);
        rd_chk("edge_wake", `EIE_OFS_EDGE_WAKE, 8'hc0);
        rd_chk("enable", `EIE_OFS_ENABLE, 8'h10);
        rd_chk("unmapped", 3'h7, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`EIE_OFS_EDGE_PRI, pat[i]);
            wr(`EIE_OFS_EDGE_WAKE, pat[i]);
            wr(`EIE_OFS_ENABLE, pat[i]);
            rd_chk("edge_pri", `EIE_OFS_EDGE_PRI, pat[i] | 8'h70);
            rd_chk("edge_wake", `EIE_OFS_EDGE_WAKE, pat[i] | 8'hc0);
            rd_chk("enable", `EIE_OFS_ENABLE, pat[i] | 8'h10);
        end
        wr(`EIE_OFS_ENABLE, 8'h00);
        $display("test registers done");

        for (int s = 0; s < 2; s++) begin
            lv = s[0];
            pins.drive_pins(lv);
            wr(`EIE_OFS_EDGE_PRI, {lv, 3'b000, {4{lv}}});
            wr(`EIE_OFS_EDGE_WAKE, {2'b00, {6{lv}}});
            wr(`EIE_OFS_REQ_FLAG, 8'h00);
            wr(`EIE_OFS_WAKE_FLAG, 8'h00);
            wr(`EIE_OFS_EVT_STAT, 8'h0f);
            n0 = nmi_cnt;
            c0 = conv_cnt;
            pins.drive_pins(~lv);
            rd_chk("req_flag", `EIE_OFS_REQ_FLAG, 8'h30);
            rd_chk("wake_flag", `EIE_OFS_WAKE_FLAG, 8'hc0);
            rd_chk("evt_stat", `EIE_OFS_EVT_STAT, 8'h00);
            pins.drive_pins(lv);
            rd_chk("req_flag", `EIE_OFS_REQ_FLAG, 8'h3f);
            rd_chk("wake_flag", `EIE_OFS_WAKE_FLAG, 8'hff);
            rd_chk("evt_stat", `EIE_OFS_EVT_STAT, 8'h0f);
            chk("nmi_pulses", 8'h01, 8'(nmi_cnt - n0));
            chk("conv_pulses", 8'h01, 8'(conv_cnt - c0));
        end
        $display("test edges done");

        pins.pulse_events(1'b1, 1'b1);
        wr(`EIE_OFS_WAKE_FLAG, 8'h04);
        rd_chk("wake_flag", `EIE_OFS_WAKE_FLAG, 8'hc4);
        for (int i = 0; i < 9; i++) begin
            e = en_tab[i];
            pins.set_mask(1'b1);
            wr(`EIE_OFS_ENABLE, e);
            pins.set_mask(1'b0);
            tick(2);
            chk("cpu_req", {1'b0, e[7:5], e[3:0]}, cpu_req);
        end
        pins.set_mask(1'b1);
        tick(2);
        chk("cpu_req", 8'h00, cpu_req);
        $display("test gating done");

        wr(`EIE_OFS_REQ_FLAG, 8'h7f);
        rd_chk("req_flag", `EIE_OFS_REQ_FLAG, 8'h7f);
        pins.set_mask(1'b0);
        fork
            wr(`EIE_OFS_REQ_FLAG, 8'h7f);
            pins.pulse_events(1'b1, 1'b0);
        join
        rd_chk("req_flag", `EIE_OFS_REQ_FLAG, 8'hff);
        chk("cpu_req", 8'h7f, cpu_req);
        pins.set_mask(1'b1);
        $display("test clear race done");

        wr(`EIE_OFS_EVT_STAT, 8'h0f);
        wr(`EIE_OFS_EVT_MASK, 8'h01);
        rd_chk("evt_mask", `EIE_OFS_EVT_MASK, 8'h01);
        pins.drive_pins(1'b0);
        pins.drive_pins(1'b1);
        tick(1);
        chk("irq_out", 8'h01, {7'h00, irq_out});
        wr(`EIE_OFS_EVT_MASK, 8'h00);
        tick(2);
        chk("irq_out", 8'h00, {7'h00, irq_out});
        wr(`EIE_OFS_EVT_MASK, 8'h0f);
        tick(2);
        chk("irq_out", 8'h01, {7'h00, irq_out});
        wr(`EIE_OFS_EVT_STAT, 8'h0f);
        tick(2);
        chk("irq_out", 8'h00, {7'h00, irq_out});
        rd_chk("evt_stat", `EIE_OFS_EVT_STAT, 8'h00);
        $display("test irq done");
        conclude();
    end
endmodule : tb
